// ---- accel_regs_pkg.sv ----
package accel_regs_pkg;

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [7:0] ADDR_RATE_SELECT   = 8'h08;
    localparam logic [7:0] ADDR_MOTION_FEATURE = 8'h09;
    localparam logic [7:0] ADDR_QUEUE_FLAGS   = 8'h0A;

    localparam logic [7:0] RATE_SELECT_RESET  = 8'h00;
    localparam logic [7:0] MOTION_FEATURE_RESET = 8'h00;
    localparam logic [7:0] QUEUE_FLAGS_RESET  = 8'h01;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    // =========================================================
    // Field positions
    // =========================================================
    localparam int RATE_CODE_LSB              = 0;
    localparam int RATE_CODE_W                = 3;
    localparam int MOTION_TILT_FLIP_BIT       = 0;
    localparam int MOTION_LATCH_BIT           = 1;
    localparam int MOTION_ANY_MOVE_BIT        = 2;
    localparam int MOTION_SHAKE_BIT           = 3;
    localparam int MOTION_TILT35_BIT          = 4;
    localparam int MOTION_POLARITY_BIT        = 5;
    localparam int MOTION_UNFILTERED_BIT      = 6;
    localparam int MOTION_RESET_BIT           = 7;
    localparam int FLAG_EMPTY_BIT             = 0;
    localparam int FLAG_FULL_BIT              = 1;
    localparam int FLAG_LEVEL_BIT             = 2;

    // =========================================================
    // Queue geometry
    // =========================================================
    localparam int QUEUE_ADDR_W               = 5;
    localparam int QUEUE_PTR_W                = 6;
    localparam logic [5:0] QUEUE_THRESHOLD_RESET = 6'h10;

    // =========================================================
    // Sample rates, in tenths of a hertz
    // =========================================================
    localparam int RATE_TENTHS_W              = 16;
    typedef logic [15:0] rate_tenths_t;
    typedef rate_tenths_t rate_table_t [8];
    localparam rate_table_t SLOW_LINK_RATES = '{16'h00FA, 16'h01F4, 16'h0271, 16'h03E8,
                                                16'h04E2, 16'h09C4, 16'h1388, 16'h2710};
    localparam rate_table_t FAST_LINK_RATES = '{16'h01F4, 16'h0271, 16'h03E8, 16'h04E2,
                                                16'h09C4, 16'h1388, 16'h2710, 16'h0000};
    localparam logic [2:0] FAST_LINK_NO_RATE  = 3'h7;
    localparam int CLK_FREQ_HZ_DEFAULT        = 100_000_000;

endpackage : accel_regs_pkg

// ---- sample_rate_divider.sv ----
`timescale 1ns/1ps

module sample_rate_divider
    import accel_regs_pkg::*;
#(
    parameter int CLK_FREQ_HZ = CLK_FREQ_HZ_DEFAULT
)(
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic [RATE_CODE_W-1:0]   rate_code,
    input  wire logic                     fast_link,
    output logic      [RATE_TENTHS_W-1:0] rate_tenths,
    output logic                          rate_valid,
    output logic                          sample_tick
);

    // =========================================================
    // Code to rate lookup
    // =========================================================
    logic [31:0] period_cycles;
    logic [31:0] count_reg;
    logic        count_done;

    assign rate_tenths   = fast_link ? FAST_LINK_RATES[rate_code] : SLOW_LINK_RATES[rate_code]; // [R2] [R3]
    assign rate_valid    = !(fast_link && rate_code == FAST_LINK_NO_RATE); // [R3]
    // Ten times the clock keeps 62.5 Hz exact without fractional math
    assign period_cycles = rate_valid ? 32'(64'(CLK_FREQ_HZ) * 64'd10 / 64'(rate_tenths)) : 32'h0;
    assign count_done    = rate_valid && count_reg >= period_cycles - 32'h1;

    // =========================================================
    // Sample tick divider
    // =========================================================
    always_ff @(posedge clk)
    begin
        if (!resetn || !rate_valid || count_done)
            count_reg <= 32'h0;
        else
            count_reg <= count_reg + 32'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            sample_tick <= 1'b0;
        else
            sample_tick <= count_done;
    end

    tick_period_a: assert property (@(posedge clk) disable iff (!resetn) // [R2] [R3]
        $rose(sample_tick) && $stable(period_cycles) |-> !rate_valid || $past(count_done))
        else $error("sample tick without divider wrap");

endmodule : sample_rate_divider

// ---- queue_pointer_flags.sv ----
`timescale 1ns/1ps

module queue_pointer_flags
    import accel_regs_pkg::*;
#(
    parameter int ADDR_W = QUEUE_ADDR_W
)(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          push,
    input  wire logic          pop,
    input  wire logic [ADDR_W:0] threshold,
    output logic               empty,
    output logic               full,
    output logic               level_flag,
    output logic [ADDR_W:0]    wr_ptr,
    output logic [ADDR_W:0]    rd_ptr
);

    // =========================================================
    // Pointer compare, top bit is the wrap marker
    // =========================================================
    logic [ADDR_W:0] occupancy;
    logic            push_ok;
    logic            pop_ok;

    assign empty      = wr_ptr == rd_ptr; // [R18] [R14]
    assign full       = wr_ptr[ADDR_W-1:0] == rd_ptr[ADDR_W-1:0] && wr_ptr[ADDR_W] != rd_ptr[ADDR_W]; // [R18] [R15]
    assign occupancy  = wr_ptr - rd_ptr;
    assign level_flag = occupancy >= threshold; // [R16]
    // A push into a full queue or a pop from an empty one is dropped
    assign push_ok    = push && !full;
    assign pop_ok     = pop && !empty;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            wr_ptr <= '0;
        else if (push_ok)
            wr_ptr <= wr_ptr + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            rd_ptr <= '0;
        else if (pop_ok)
            rd_ptr <= rd_ptr + 1'b1;
    end

    full_count_a: assert property (@(posedge clk) disable iff (!resetn) // [R15]
        full == (occupancy == (ADDR_W+1)'(1 << ADDR_W)))
        else $error("full flag disagrees with occupancy");

    no_overrun_a: assert property (@(posedge clk) disable iff (!resetn) // [R18]
        full && !pop |=> full && $stable(wr_ptr))
        else $error("push moved a full queue");

endmodule : queue_pointer_flags

// ---- accel_rate_motion_fifo_regs.sv ----
`timescale 1ns/1ps

// Overview of operation
// (R1) Rate register read/write, resets zero, upper zeros; code stores bits 7:3 as written
// (R2) Slow link: codes give 25 to 1000 Hz
// (R3) Fast link: codes 0-6 give 50-1000 Hz
// (R4) Motion bit 0 enables tilt/flip
// (R5) Motion bit 1 latches motion outputs
// (R6) Motion bit 2 enables any-motion detection
// (R7) Bit 3 shake, needs any-motion too
// (R8) Bit 4 tilt-35, needs any-motion too
// (R9) Bit 5 flips Z-axis polarity
// (R10) Bit 6 selects raw motion flags
// (R11) Bit 7 holds motion reset until cleared
// (R12) Queue flags read live, not captured
// (R13) Queue flags ignore interrupt enables
// (R14) Bit 0 empty, set after reset
// (R15) Bit 1 full at capacity
// (R16) Bit 2 level at or above threshold
// (R17) Queue flag bits 7:3 read zero
// (R18) Pointers carry wrap bit for full/empty
// (R19) Writes to queue flags change nothing

module accel_rate_motion_fifo_regs
    import accel_regs_pkg::*;
#(
    parameter int CLK_FREQ_HZ = CLK_FREQ_HZ_DEFAULT
)(
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    output logic                           reg_rvalid,
    input  wire logic                      fast_link,
    input  wire logic                      sample_push,
    input  wire logic                      sample_pop,
    input  wire logic [QUEUE_PTR_W-1:0]    queue_threshold,
    input  wire logic                      queue_irq_enable,
    output logic      [RATE_CODE_W-1:0]    internal_sample_rate,
    output logic      [RATE_TENTHS_W-1:0]  output_sample_rate,
    output logic                           rate_valid,
    output logic                           sample_tick,
    output logic                           tilt_flip_enable,
    output logic                           motion_latch_enable,
    output logic                           any_movement_enable,
    output logic                           shake_enable,
    output logic                           tilt35_enable,
    output logic                           vertical_polarity_select,
    output logic                           unfiltered_flag_select,
    output logic                           motion_block_reset,
    output logic                           queue_empty,
    output logic                           queue_full,
    output logic                           queue_level_flag
);

    // =========================================================
    // Address decode
    // =========================================================
    logic [7:0] rate_reg;
    logic [7:0] motion_reg;
    logic [7:0] read_mux;
    logic [7:0] queue_flags;
    logic       wr_rate;
    logic       wr_motion;
    logic       hit_rate;
    logic       hit_motion;
    logic       hit_flags;
    logic       live_empty;
    logic       live_full;
    logic       live_level;
    logic       live_valid;
    logic       gated_shake;
    logic       gated_tilt35;
    logic [RATE_TENTHS_W-1:0] live_rate;
    logic [QUEUE_PTR_W-1:0]   wr_ptr;
    logic [QUEUE_PTR_W-1:0]   rd_ptr;

    assign hit_rate     = reg_addr == ADDR_RATE_SELECT;
    assign hit_motion   = reg_addr == ADDR_MOTION_FEATURE;
    assign hit_flags    = reg_addr == ADDR_QUEUE_FLAGS;
    assign wr_rate      = reg_wr && hit_rate;
    assign wr_motion    = reg_wr && hit_motion;
    // No write strobe reaches the queue, so its flags are never disturbed by software
    assign queue_flags  = {5'h00, live_level, live_full, live_empty}; // [R12] [R13] [R17] [R19]

    // Motion control is write-only and reads back as zero
    assign read_mux     = hit_rate  ? rate_reg :  // [R1]
                          hit_flags ? queue_flags :
                          UNMAPPED_READ;

    // =========================================================
    // Rate select register
    // =========================================================
    // Upper bits are stored as written; keeping them zero is up to software
    always_ff @(posedge clk)
    begin
        if (!resetn)
            rate_reg <= RATE_SELECT_RESET; // [R1]
        else if (wr_rate)
            rate_reg <= reg_wdata; // [R1]
    end

    // =========================================================
    // Motion control register
    // =========================================================
    assign gated_shake  = motion_reg[MOTION_SHAKE_BIT] && motion_reg[MOTION_ANY_MOVE_BIT]; // [R7]
    assign gated_tilt35 = motion_reg[MOTION_TILT35_BIT] && motion_reg[MOTION_ANY_MOVE_BIT]; // [R8]

    always_ff @(posedge clk)
    begin
        if (!resetn)
            motion_reg <= MOTION_FEATURE_RESET;
        else if (wr_motion)
            motion_reg <= reg_wdata; // [R4] [R5] [R6] [R9] [R10] [R11]
    end

    // =========================================================
    // Registered outputs towards the motion engine
    // =========================================================
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tilt_flip_enable         <= 1'b0;
            motion_latch_enable      <= 1'b0;
            any_movement_enable      <= 1'b0;
            shake_enable             <= 1'b0;
            tilt35_enable            <= 1'b0;
            vertical_polarity_select <= 1'b0;
            unfiltered_flag_select   <= 1'b0;
            motion_block_reset       <= 1'b0;
        end
        else
        begin
            tilt_flip_enable         <= motion_reg[MOTION_TILT_FLIP_BIT]; // [R4]
            motion_latch_enable      <= motion_reg[MOTION_LATCH_BIT]; // [R5]
            any_movement_enable      <= motion_reg[MOTION_ANY_MOVE_BIT]; // [R6]
            shake_enable             <= gated_shake; // [R7]
            tilt35_enable            <= gated_tilt35; // [R8]
            vertical_polarity_select <= motion_reg[MOTION_POLARITY_BIT]; // [R9]
            unfiltered_flag_select   <= motion_reg[MOTION_UNFILTERED_BIT]; // [R10]
            motion_block_reset       <= motion_reg[MOTION_RESET_BIT]; // [R11]
        end
    end

    // =========================================================
    // Rate decode and sample divider
    // =========================================================
    sample_rate_divider #(
        .CLK_FREQ_HZ (CLK_FREQ_HZ)
    ) u_divider (
        .clk         (clk),
        .resetn      (resetn),
        .rate_code   (rate_reg[RATE_CODE_LSB +: RATE_CODE_W]),
        .fast_link   (fast_link),
        .rate_tenths (live_rate),
        .rate_valid  (live_valid),
        .sample_tick (sample_tick)
    );

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            internal_sample_rate <= '0;
            output_sample_rate   <= '0;
            rate_valid           <= 1'b0;
        end
        else
        begin
            internal_sample_rate <= rate_reg[RATE_CODE_LSB +: RATE_CODE_W]; // [R2]
            output_sample_rate   <= live_rate; // [R2] [R3]
            rate_valid           <= live_valid; // [R3]
        end
    end

    // =========================================================
    // Queue pointers and flags
    // =========================================================
    queue_pointer_flags #(
        .ADDR_W     (QUEUE_ADDR_W)
    ) u_queue (
        .clk        (clk),
        .resetn     (resetn),
        .push       (sample_push),
        .pop        (sample_pop),
        .threshold  (queue_threshold),
        .empty      (live_empty),
        .full       (live_full),
        .level_flag (live_level),
        .wr_ptr     (wr_ptr),
        .rd_ptr     (rd_ptr)
    );

    // Mirrors of the flags lag one cycle; the read path uses the live value
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            queue_empty      <= QUEUE_FLAGS_RESET[FLAG_EMPTY_BIT]; // [R14]
            queue_full       <= QUEUE_FLAGS_RESET[FLAG_FULL_BIT];
            queue_level_flag <= QUEUE_FLAGS_RESET[FLAG_LEVEL_BIT];
        end
        else
        begin
            queue_empty      <= live_empty; // [R14]
            queue_full       <= live_full; // [R15]
            queue_level_flag <= live_level; // [R16]
        end
    end

    // =========================================================
    // Read answer
    // =========================================================
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rdata  <= reg_rd ? read_mux : 8'h00;
            reg_rvalid <= reg_rd;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    sequence motion_reset_set_s;
        wr_motion && reg_wdata[MOTION_RESET_BIT];
    endsequence

    sequence reset_held_s;
        !wr_motion [*2];
    endsequence

    rate_reset_a: assert property (@(posedge clk) // [R1]
        !resetn |=> rate_reg == RATE_SELECT_RESET && motion_reg == MOTION_FEATURE_RESET)
        else $error("registers not cleared by reset");

    rate_write_a: assert property (@(posedge clk) disable iff (!resetn) // [R1]
        reg_rd && hit_rate && !wr_rate ##1 reg_rvalid |-> reg_rdata == $past(rate_reg))
        else $error("rate register read back wrong");

    slow_top_a: assert property (@(posedge clk) disable iff (!resetn) // [R2]
        !fast_link && rate_reg[2:0] == 3'h7 |-> live_rate == 16'h2710 && live_valid)
        else $error("slow link code 7 is not 1000 Hz");

    fast_gap_a: assert property (@(posedge clk) disable iff (!resetn) // [R3]
        fast_link |-> live_valid == (rate_reg[2:0] != 3'h7) && (rate_reg[2:0] != 3'h0 || live_rate == 16'h01F4))
        else $error("fast link decode wrong");

    tilt_flip_a: assert property (@(posedge clk) disable iff (!resetn) // [R4]
        wr_motion ##1 !wr_motion |=> tilt_flip_enable == $past(reg_wdata[MOTION_TILT_FLIP_BIT], 2))
        else $error("tilt/flip enable not following write");

    latch_any_a: assert property (@(posedge clk) disable iff (!resetn) // [R5] [R6]
        ##1 motion_latch_enable == $past(motion_reg[MOTION_LATCH_BIT])
            && any_movement_enable == $past(motion_reg[MOTION_ANY_MOVE_BIT]))
        else $error("latch or any-motion output wrong");

    shake_gate_a: assert property (@(posedge clk) disable iff (!resetn) // [R7]
        shake_enable |-> any_movement_enable)
        else $error("shake active without any-motion");

    tilt35_gate_a: assert property (@(posedge clk) disable iff (!resetn) // [R8]
        tilt35_enable |-> any_movement_enable && $past(motion_reg[MOTION_TILT35_BIT]))
        else $error("tilt-35 active without its enables");

    polarity_raw_a: assert property (@(posedge clk) disable iff (!resetn) // [R9] [R10]
        ##1 vertical_polarity_select == $past(motion_reg[MOTION_POLARITY_BIT])
            && unfiltered_flag_select == $past(motion_reg[MOTION_UNFILTERED_BIT]))
        else $error("polarity or raw select wrong");

    motion_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        motion_reset_set_s ##1 reset_held_s |-> motion_block_reset)
        else $error("motion reset released without a write");

    flags_live_a: assert property (@(posedge clk) disable iff (!resetn) // [R12] [R13] [R17]
        reg_rd && hit_flags |=> reg_rdata == {5'h00, $past(live_level), $past(live_full), $past(live_empty)})
        else $error("queue flag read wrong");

    empty_boot_a: assert property (@(posedge clk) // [R14]
        !resetn |=> live_empty && !live_full)
        else $error("queue not empty after reset");

    fill_level_a: assert property (@(posedge clk) disable iff (!resetn) // [R16]
        live_level == ((wr_ptr - rd_ptr) >= queue_threshold))
        else $error("level flag disagrees with fill");

    flag_write_a: assert property (@(posedge clk) disable iff (!resetn) // [R19]
        reg_wr && hit_flags && !sample_push && !sample_pop |=> $stable(wr_ptr) && $stable(rd_ptr))
        else $error("write to queue flags moved a pointer");

    // The enable is deliberately unused by the flags; this proves it stays that way
    irq_ignored_a: assert property (@(posedge clk) disable iff (!resetn) // [R13]
        !sample_push && !sample_pop && $changed(queue_irq_enable)
            |=> $changed(queue_threshold) || $stable({live_level, live_full, live_empty}))
        else $error("queue flags moved with interrupt enable");

endmodule : accel_rate_motion_fifo_regs

// ---- reg_host_model.sv ----
`timescale 1ns/1ps

module reg_host_model (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    int idle_cycles = 0;

    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // =========================================================
    // Byte transfers from the serial engine
    // =========================================================
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        repeat (idle_cycles) @(posedge clk);
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        // Released lines change so stale values cannot pass for valid ones
        reg_addr  <= ~addr;
        reg_wdata <= ~data;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        data = 8'hXX;
        repeat (idle_cycles) @(posedge clk);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~addr;
        for (int n = 0; n < 4; n++)
        begin
            @(posedge clk);
            if (reg_rvalid === 1'b1)
            begin
                data = reg_rdata;
                break;
            end
        end
    endtask : read_reg
endmodule : reg_host_model

// ---- test_accel_rate_motion_fifo_regs.sv ----
`timescale 1ns/1ps

module test_accel_rate_motion_fifo_regs;
    import accel_regs_pkg::*;

    localparam int CLK_HZ = 10000;
    localparam logic [15:0] SLOW_EXP [8] = '{16'h00FA, 16'h01F4, 16'h0271, 16'h03E8,
                                             16'h04E2, 16'h09C4, 16'h1388, 16'h2710};
    localparam logic [15:0] FAST_EXP [8] = '{16'h01F4, 16'h0271, 16'h03E8, 16'h04E2,
                                             16'h09C4, 16'h1388, 16'h2710, 16'h0000};

    logic        clk, resetn, reg_wr, reg_rd, reg_rvalid, fast_link, sample_push, sample_pop;
    logic        queue_irq_enable, rate_valid, sample_tick, queue_empty, queue_full, queue_level_flag;
    logic        tilt_flip_enable, motion_latch_enable, any_movement_enable, shake_enable;
    logic        tilt35_enable, vertical_polarity_select, unfiltered_flag_select, motion_block_reset;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, wv, rd;
    logic [5:0]  queue_threshold;
    logic [2:0]  internal_sample_rate;
    logic [15:0] output_sample_rate;
    logic [7:0]  motion_vec;
    logic        p, q;
    int          fails, samples_checked, seed, count, n;

    assign motion_vec = {motion_block_reset, unfiltered_flag_select, vertical_polarity_select, tilt35_enable,
                         shake_enable, any_movement_enable, motion_latch_enable, tilt_flip_enable};

    accel_rate_motion_fifo_regs #(.CLK_FREQ_HZ(CLK_HZ)) dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fast_link(fast_link),
        .sample_push(sample_push), .sample_pop(sample_pop), .queue_threshold(queue_threshold),
        .queue_irq_enable(queue_irq_enable), .internal_sample_rate(internal_sample_rate),
        .output_sample_rate(output_sample_rate), .rate_valid(rate_valid), .sample_tick(sample_tick),
        .tilt_flip_enable(tilt_flip_enable), .motion_latch_enable(motion_latch_enable),
        .any_movement_enable(any_movement_enable), .shake_enable(shake_enable),
        .tilt35_enable(tilt35_enable), .vertical_polarity_select(vertical_polarity_select),
        .unfiltered_flag_select(unfiltered_flag_select), .motion_block_reset(motion_block_reset),
        .queue_empty(queue_empty), .queue_full(queue_full), .queue_level_flag(queue_level_flag));

    reg_host_model host (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // =========================================================
    // Checking helpers
    // =========================================================
    function automatic logic [7:0] motion_exp(input logic [7:0] v);
        motion_exp    = v;
        motion_exp[3] = v[3] & v[2];
        motion_exp[4] = v[4] & v[2];
    endfunction : motion_exp

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_tick(output int cyc);
        cyc = 0;
        do
        begin
            @(posedge clk);
            cyc++;
        end
        while (sample_tick !== 1'b1 && cyc < 3000);
    endtask : wait_tick

    task automatic close_out;
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // =========================================================
    // Clock, watchdog and main sequence
    // =========================================================
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #200000;
        fails++;
        close_out();
    end

    initial
    begin
        seed = 6191;
        fails = 0;
        samples_checked = 0;
        count = 0;
        resetn = 1'b0;
        fast_link = 1'b0;
        sample_push = 1'b0;
        sample_pop = 1'b0;
        queue_threshold = QUEUE_THRESHOLD_RESET;
        queue_irq_enable = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        check("empty_at_reset", 16'h0001, 16'(queue_empty));
        check("motion_at_reset", 16'h0000, 16'(motion_vec));
        host.read_reg(ADDR_RATE_SELECT, rd);
        check("rate_reset", 16'h0000, 16'(rd));
        host.read_reg(ADDR_QUEUE_FLAGS, rd);
        check("flags_reset", 16'h0001, 16'(rd));
        for (int f = 0; f < 2; f++)
            for (int c = 0; c < 8; c++)
            begin
                fast_link <= f[0];
                // Bit 3 or bit 4 is set along with the code, so the upper bits are not all zero; bits 7:5 stay zero
                wv = (f == 1) ? (8'h08 | 8'(c)) : (8'h10 | 8'(c));
                host.write_reg(ADDR_RATE_SELECT, wv);
                repeat (3) @(posedge clk);
                host.read_reg(ADDR_RATE_SELECT, rd);
                check("rate_readback", 16'(wv), 16'(rd));
                check("rate_code", 16'(c), 16'(internal_sample_rate));
                check("rate_tenths", (f == 1) ? FAST_EXP[c] : SLOW_EXP[c], output_sample_rate);
                check("rate_valid", 16'(!(f == 1 && c == 7)), 16'(rate_valid));
            end
        fast_link <= 1'b0;
        host.write_reg(ADDR_RATE_SELECT, 8'h13);
        repeat (3) wait_tick(n);
        check("tick_period", 16'(CLK_HZ * 10 / 1000), 16'(n));
        for (int i = 0; i < 20; i++)
        begin
            // Corners: shake without any-motion, reset held, then released
            wv = (i == 0) ? 8'h08 : (i == 1) ? 8'h90 : (i == 2) ? 8'h14 : 8'($random(seed));
            host.write_reg(ADDR_MOTION_FEATURE, wv);
            repeat (2) @(posedge clk);
            check("motion_outs", 16'(motion_exp(wv)), 16'(motion_vec));
        end
        host.read_reg(ADDR_MOTION_FEATURE, rd);
        check("motion_read", 16'h0000, 16'(rd));
        host.write_reg(8'h3F, 8'hA5);
        host.read_reg(8'h3F, rd);
        check("unmapped_read", 16'h0000, 16'(rd));
        for (int i = 0; i < 120; i++)
        begin
            p = (i < 36) ? 1'b1 : (i < 72) ? 1'b0 : 1'($random(seed));
            q = (i >= 36 && i < 72) ? 1'b1 : (i < 36) ? 1'b0 : 1'($random(seed));
            host.idle_cycles = i % 3;
            @(posedge clk);
            sample_push <= p;
            sample_pop <= q;
            queue_irq_enable <= 1'($random(seed));
            if (i >= 72)
                queue_threshold <= 6'($unsigned($random(seed)) % 34);
            @(posedge clk);
            sample_push <= 1'b0;
            sample_pop <= 1'b0;
            count = count + ((p && count < 32) ? 1 : 0) - ((q && count > 0) ? 1 : 0);
            repeat (3) @(posedge clk);
            check("queue_empty", 16'(count == 0), 16'(queue_empty));
            check("queue_full", 16'(count == 32), 16'(queue_full));
            check("queue_level", 16'(count >= int'(queue_threshold)), 16'(queue_level_flag));
            if (i % 8 == 5)
            begin
                host.write_reg(ADDR_QUEUE_FLAGS, 8'hFF);
                host.read_reg(ADDR_QUEUE_FLAGS, rd);
                check("flags_read", {13'h0000, queue_level_flag, queue_full, queue_empty}, 16'(rd));
            end
        end
        close_out();
    end
endmodule : test_accel_rate_motion_fifo_regs
